// >>> freq_counter_regs.vh
`ifndef FREQ_COUNTER_REGS_VH
`define FREQ_COUNTER_REGS_VH

`define REG_CTRL 4'h0
`define REG_SETPOINT_A 4'h1
`define REG_SETPOINT_B 4'h2
`define REG_ACTUAL_A 4'h3
`define REG_ACTUAL_B 4'h4
`define REG_CONTACT 4'h5
`define REG_INT_STATUS 4'h6
`define REG_INT_CLEAR 4'h7
`define REG_INT_ENABLE 4'h8

`define CTRL_MODE_A_BIT 0
`define CTRL_MODE_B_BIT 1
`define INT_DONE_A_BIT 0
`define INT_DONE_B_BIT 1
`define INT_CONTACT_A_BIT 2
`define INT_CONTACT_B_BIT 3

`define CTRL_RESET 2'h3
`define SETPOINT_RESET 16'h0000
`define INT_ENABLE_RESET 4'h0

`define FREQ_MIN 16'h0004
`define FREQ_MAX 16'h03e8
`define COUNT_MAX 16'h7d00

// One second of 20 ns clock cycles
`define GATE_CYCLES_DEF 26'h2faf080

`endif

// >>> pulse_input_sync.v
`timescale 1ns/1ps
module pulse_input_sync (
   input wire ref_clk_in,
   input wire reset_in,
   input wire pin_in,
   output wire rise_out
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg level_q;
   wire level_d;

   // Level accepted once second and third stages agree
   assign level_d = (s2_q == s3_q) ? s3_q : level_q;
   assign rise_out = level_d & ~level_q;

   always @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         level_q <= level_d;
      end
   end
endmodule

// >>> gated_frequency_counter.v
`timescale 1ns/1ps
`include "freq_counter_regs.vh"
module gated_frequency_counter #(
   parameter [25:0] GATE_CYCLES = `GATE_CYCLES_DEF
) (
   input wire ref_clk_in,
   input wire reset_in,
   input wire [3:0] reg_addr_in,
   input wire [15:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output wire [15:0] reg_rdata_out,
   input wire fast_input_three_in,
   input wire fast_input_four_in,
   input wire freq_a_enable_coil_in,
   input wire freq_b_enable_coil_in,
   input wire freq_a_clear_coil_in,
   input wire freq_b_clear_coil_in,
   input wire freq_a_direction_coil_in,
   input wire freq_b_direction_coil_in,
   input wire cycle_tick_in,
   output wire freq_channel_a_contact_out,
   output wire freq_channel_b_contact_out,
   output wire irq_out
);
   localparam [25:0] GATE_LAST = GATE_CYCLES - 26'd1;

   reg [1:0] ctrl_q;
   reg [15:0] setpoint_a_q;
   reg [15:0] setpoint_b_q;
   reg [3:0] int_status_q;
   reg [3:0] int_enable_q;
   reg [15:0] rdata_q;

   wire [1:0] pulse_rise;
   wire [1:0] enable_coil;
   wire [1:0] clear_coil;
   wire [1:0] dir_coil;
   wire [31:0] setpoint_all;
   wire [31:0] actual_all;
   wire [1:0] done_ev;
   wire [1:0] contact_ev;
   wire [1:0] contact_all;
   wire [3:0] int_events;
   wire [3:0] int_clear;

   // Clamp a finished gate count into the measurable band
   function [15:0] clamp_freq;
      input [15:0] n;
      begin
         if (n > `FREQ_MAX) begin
            clamp_freq = `FREQ_MAX;
         end else if (n < `FREQ_MIN) begin
            clamp_freq = `FREQ_MIN;
         end else begin
            clamp_freq = n;
         end
      end
   endfunction

   // Fixed routing of the fast inputs
   pulse_input_sync u_sync_a (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .pin_in(fast_input_three_in),
      .rise_out(pulse_rise[0])
   );

   pulse_input_sync u_sync_b (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .pin_in(fast_input_four_in),
      .rise_out(pulse_rise[1])
   );

   assign enable_coil = {freq_b_enable_coil_in, freq_a_enable_coil_in};
   assign clear_coil = {freq_b_clear_coil_in, freq_a_clear_coil_in};
   assign dir_coil = {freq_b_direction_coil_in, freq_a_direction_coil_in};
   assign setpoint_all = {setpoint_b_q, setpoint_a_q};

   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1) begin : chan
         reg [25:0] gate_q;
         reg [15:0] pulses_q;
         reg [15:0] actual_q;
         reg valid_q;
         reg mode_q;
         reg coil_prev_q;
         reg contact_q;
         reg done_q;
         reg contact_ev_q;
         wire freq_mode;
         wire [15:0] setpoint;
         wire [15:0] pulses_next;
         wire coil_rise;
         wire compare;

         assign freq_mode = ctrl_q[i];
         assign setpoint = setpoint_all[i*16 +: 16];
         assign coil_rise = enable_coil[i] & ~coil_prev_q;
         assign pulses_next = (pulses_q == 16'hffff) ? pulses_q :
                              pulses_q + {15'h0000, pulse_rise[i]};
         // Comparison gated by valid_q: set by a finished gate in frequency mode, always set in counter mode
         assign compare = valid_q && (actual_q >= setpoint);

         always @(posedge ref_clk_in or posedge reset_in) begin
            if (reset_in) begin
               gate_q <= 26'h0000000;
               pulses_q <= 16'h0000;
               actual_q <= 16'h0000;
               valid_q <= 1'b0;
               mode_q <= 1'b1;
               coil_prev_q <= 1'b0;
               done_q <= 1'b0;
            end else begin
               mode_q <= freq_mode;
               coil_prev_q <= enable_coil[i];
               done_q <= 1'b0;
               if (mode_q != freq_mode) begin
                  // Mode change restarts the channel from zero
                  gate_q <= 26'h0000000;
                  pulses_q <= 16'h0000;
                  actual_q <= 16'h0000;
                  valid_q <= 1'b0;
               end else if (freq_mode) begin
                  // Direction coil deliberately unused here
                  if (clear_coil[i] || !enable_coil[i]) begin
                     gate_q <= 26'h0000000;
                     pulses_q <= 16'h0000;
                     actual_q <= 16'h0000;
                     valid_q <= 1'b0;
                  end else if (gate_q == GATE_LAST) begin
                     gate_q <= 26'h0000000;
                     pulses_q <= 16'h0000;
                     actual_q <= clamp_freq(pulses_next);
                     valid_q <= 1'b1;
                     done_q <= 1'b1;
                  end else begin
                     gate_q <= gate_q + 26'd1;
                     pulses_q <= pulses_next;
                  end
               end else begin
                  // Up/down counter on the enable coil edge
                  gate_q <= 26'h0000000;
                  pulses_q <= 16'h0000;
                  valid_q <= 1'b1;
                  if (clear_coil[i]) begin
                     actual_q <= 16'h0000;
                  end else if (coil_rise) begin
                     if (dir_coil[i]) begin
                        if (actual_q != 16'h0000) begin
                           actual_q <= actual_q - 16'd1;
                        end
                     end else if (actual_q < `COUNT_MAX) begin
                        actual_q <= actual_q + 16'd1;
                     end
                  end
               end
            end
         end

         // Contact refreshed only on the program cycle tick
         always @(posedge ref_clk_in or posedge reset_in) begin
            if (reset_in) begin
               contact_q <= 1'b0;
               contact_ev_q <= 1'b0;
            end else begin
               contact_ev_q <= 1'b0;
               if (cycle_tick_in) begin
                  contact_q <= compare;
                  contact_ev_q <= compare & ~contact_q;
               end
            end
         end

         assign actual_all[i*16 +: 16] = actual_q;
         assign done_ev[i] = done_q;
         assign contact_ev[i] = contact_ev_q;
         assign contact_all[i] = contact_q;
      end
   endgenerate

   assign freq_channel_a_contact_out = contact_all[0];
   assign freq_channel_b_contact_out = contact_all[1];

   // Interrupt status, set beats clear
   assign int_events = {contact_ev, done_ev};
   assign int_clear = (reg_wr_in && reg_addr_in == `REG_INT_CLEAR) ?
                      reg_wdata_in[3:0] : 4'h0;
   assign irq_out = |(int_status_q & int_enable_q);

   always @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         int_status_q <= 4'h0;
      end else begin
         int_status_q <= (int_status_q & ~int_clear) | int_events;
      end
   end

   // Register writes
   always @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         ctrl_q <= `CTRL_RESET;
         setpoint_a_q <= `SETPOINT_RESET;
         setpoint_b_q <= `SETPOINT_RESET;
         int_enable_q <= `INT_ENABLE_RESET;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `REG_CTRL: begin
               ctrl_q <= reg_wdata_in[1:0];
            end
            `REG_SETPOINT_A: begin
               if (reg_wdata_in <= `COUNT_MAX) begin
                  setpoint_a_q <= reg_wdata_in;
               end
            end
            `REG_SETPOINT_B: begin
               if (reg_wdata_in <= `COUNT_MAX) begin
                  setpoint_b_q <= reg_wdata_in;
               end
            end
            `REG_INT_ENABLE: begin
               int_enable_q <= reg_wdata_in[3:0];
            end
            default: begin
               ctrl_q <= ctrl_q;
            end
         endcase
      end
   end

   // Register reads, data one cycle after strobe
   always @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         rdata_q <= 16'h0000;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `REG_CTRL: rdata_q <= {14'h0000, ctrl_q};
            `REG_SETPOINT_A: rdata_q <= setpoint_a_q;
            `REG_SETPOINT_B: rdata_q <= setpoint_b_q;
            `REG_ACTUAL_A: rdata_q <= actual_all[15:0];
            `REG_ACTUAL_B: rdata_q <= actual_all[31:16];
            `REG_CONTACT: rdata_q <= {14'h0000, contact_all};
            `REG_INT_STATUS: rdata_q <= {12'h000, int_status_q};
            `REG_INT_ENABLE: rdata_q <= {12'h000, int_enable_q};
            default: rdata_q <= 16'h0000;
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign reg_rdata_out = rdata_q;
endmodule

// >>> pulse_src.sv
`timescale 1ns/1ps
module pulse_src (
   input logic clk_in,
   input logic [15:0] half_in,
   output logic pin_out
);
   logic [15:0] cnt_q = 16'h0000;
   initial pin_out = 1'b0;
   // Square wave, equal high and low, zero half period parks low
   always @(posedge clk_in) begin
      if (half_in == 16'h0000) begin
         pin_out <= 1'b0;
         cnt_q <= 16'h0000;
      end else if (cnt_q + 16'h0001 >= half_in) begin
         pin_out <= ~pin_out;
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
endmodule

// >>> gated_frequency_counter_sva.sv
`timescale 1ns/1ps
module gfc_sva (
   input logic ref_clk_in,
   input logic reset_in,
   input logic [3:0] reg_addr_in,
   input logic [15:0] reg_wdata_in,
   input logic reg_wr_in,
   input logic reg_rd_in,
   input logic [15:0] reg_rdata_out,
   input logic cycle_tick_in,
   input logic freq_channel_a_contact_out,
   input logic freq_channel_b_contact_out,
   input logic irq_out
);
   logic [1:0] mode_q;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   // Shadow of the mode bits
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) mode_q <= 2'h3;
      else if (reg_wr_in && reg_addr_in == 4'h0) mode_q <= reg_wdata_in[1:0];
   end
   a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
      else $error("read data not zero outside read slot");
   a_contact_a_tick: assert property ($changed(freq_channel_a_contact_out) |-> $past(cycle_tick_in))
      else $error("contact a moved without tick");
   a_contact_b_tick: assert property ($changed(freq_channel_b_contact_out) |-> $past(cycle_tick_in))
      else $error("contact b moved without tick");
   a_irq_masked: assert property (reg_wr_in && reg_addr_in == 4'h8 && reg_wdata_in[3:0] == 4'h0
      |=> !irq_out) else $error("irq high with all enables off");
   a_unmapped_zero: assert property (reg_rd_in && reg_addr_in > 4'h8 |=> reg_rdata_out == 16'h0000)
      else $error("unmapped read not zero");
   a_actual_range: assert property (reg_rd_in && ((reg_addr_in == 4'h3 && mode_q[0]) ||
      (reg_addr_in == 4'h4 && mode_q[1])) |=> reg_rdata_out == 16'h0000 ||
      (reg_rdata_out >= 16'h0004 && reg_rdata_out <= 16'h03e8)) else $error("actual out of range");
   a_setpoint_store: assert property (reg_wr_in && reg_addr_in inside {4'h1, 4'h2}
      && reg_wdata_in <= 16'h7d00 ##1 reg_rd_in && reg_addr_in == $past(reg_addr_in)
      |=> reg_rdata_out == $past(reg_wdata_in, 2))
      else $error("setpoint not stored");
   a_mode_store: assert property (reg_wr_in && reg_addr_in == 4'h0 ##1 reg_rd_in &&
      reg_addr_in == 4'h0 |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 16'h0003))
      else $error("mode bits not stored");
   c_contact_rise: cover property ($rose(freq_channel_a_contact_out));
   c_irq_rise: cover property ($rose(irq_out));
   c_unmapped: cover property (reg_rd_in && reg_addr_in > 4'h8);
endmodule
bind gated_frequency_counter gfc_sva chk_u (.ref_clk_in, .reset_in, .reg_addr_in, .reg_wdata_in,
   .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cycle_tick_in, .freq_channel_a_contact_out,
   .freq_channel_b_contact_out, .irq_out);

// >>> tb_gated_frequency_counter.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_gated_frequency_counter;
   localparam int GATE = 8000;
   logic clk = 0, rst = 1, wr = 0, rd = 0, tick = 0, dir = 0;
   logic en_a = 0, en_b = 0, clr_a = 0, clr_b = 0, pin_a, pin_b, ct_a, ct_b, irq;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000, rdata, v, ha = 16'h0000, hb = 16'h0000;
   int n_fail = 0, compares = 0;
   initial forever #10 clk = ~clk;
   pulse_src src_a (.clk_in(clk), .half_in(ha), .pin_out(pin_a));
   pulse_src src_b (.clk_in(clk), .half_in(hb), .pin_out(pin_b));
   gated_frequency_counter #(.GATE_CYCLES(26'd8000)) dut_u (.ref_clk_in(clk), .reset_in(rst),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .fast_input_three_in(pin_a), .fast_input_four_in(pin_b),
      .freq_a_enable_coil_in(en_a), .freq_b_enable_coil_in(en_b),
      .freq_a_clear_coil_in(clr_a), .freq_b_clear_coil_in(clr_b),
      .freq_a_direction_coil_in(dir), .freq_b_direction_coil_in(dir), .cycle_tick_in(tick),
      .freq_channel_a_contact_out(ct_a), .freq_channel_b_contact_out(ct_b), .irq_out(irq));
   task automatic wreg(input logic [3:0] a, input logic [15:0] d);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      v = rdata;
   endtask
   task automatic tk;
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      test_done;
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rreg(4'h0); `CHK("ctrl", 16'h0003, v)
      rreg(4'h1); `CHK("sp_a", 16'h0000, v)
      rreg(4'hf); `CHK("unmapped", 16'h0000, v)
      wreg(4'h2, 16'h7d00);
      rreg(4'h2); `CHK("sp_b", 16'h7d00, v)
      wreg(4'h2, 16'h7d01);
      rreg(4'h2); `CHK("sp_b", 16'h7d00, v)
      wreg(4'h2, 16'h03e8);
      wreg(4'h1, 16'h0096);
      wreg(4'h8, 16'h000f);
      ha <= 16'h0014;
      hb <= 16'h0004;
      dir <= 1'b1;
      en_a <= 1'b1;
      en_b <= 1'b1;
      repeat (100) @(posedge clk);
      tk; `CHK("ct_a", 1'b0, ct_a)
      repeat (GATE) @(posedge clk);
      rreg(4'h3); `CHK("act_a", 1'b1, v >= 16'h00c7 && v <= 16'h00c9)
      rreg(4'h4); `CHK("act_b", 16'h03e8, v)
      rreg(4'h6); `CHK("status", 16'h0003, v)
      tk; `CHK("ct_a", 1'b1, ct_a)
      `CHK("ct_b", 1'b1, ct_b)
      rreg(4'h6); `CHK("status", 16'h000f, v)
      `CHK("irq", 1'b1, irq)
      wreg(4'h8, 16'h0000);
      wreg(4'h7, 16'h000f);
      rreg(4'h6); `CHK("status", 16'h0000, v)
      `CHK("irq", 1'b0, irq)
      ha <= 16'h03e8;
      repeat (2 * GATE) @(posedge clk);
      rreg(4'h3); `CHK("act_a", 16'h0004, v)
      `CHK("ct_a", 1'b1, ct_a)
      tk; `CHK("ct_a", 1'b0, ct_a)
      clr_a <= 1'b1;
      en_b <= 1'b0;
      repeat (3) @(posedge clk);
      rreg(4'h3); `CHK("act_a", 16'h0000, v)
      rreg(4'h4); `CHK("act_b", 16'h0000, v)
      tk; `CHK("ct_b", 1'b0, ct_b)
      en_b <= 1'b1;
      repeat (GATE + 10) @(posedge clk);
      rreg(4'h4); `CHK("act_b", 16'h03e8, v)
      clr_b <= 1'b1;
      repeat (3) @(posedge clk);
      rreg(4'h4); `CHK("act_b", 16'h0000, v)
      wreg(4'h0, 16'h0002);
      rreg(4'h0); `CHK("ctrl", 16'h0002, v)
      clr_a <= 1'b0;
      dir <= 1'b0;
      repeat (3) begin
         en_a <= 1'b0;
         @(posedge clk);
         en_a <= 1'b1;
         @(posedge clk);
      end
      rreg(4'h3); `CHK("cnt_a", 16'h0003, v)
      dir <= 1'b1;
      en_a <= 1'b0;
      @(posedge clk);
      en_a <= 1'b1;
      @(posedge clk);
      rreg(4'h3); `CHK("cnt_a", 16'h0002, v)
      test_done;
   end
endmodule
